// ==== sim/tb_kr_sequencer_control_regs.sv ====
// Purpose: Self-checking bench for the sequencer control and status words.
// Assumes: Default build option, so FEC advertise resets to zero.
// Notes: Stimulus changes on the rising edge by non-blocking assignment.
`timescale 1ns/1ps
`default_nettype none
module tb_kr_sequencer_control_regs;
  import seqctl_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic [ADDR_W-1:0] ADDRESS = 8'h00;
  logic WRITE = 1'b0;
  logic READ = 1'b0;
  logic [DATA_W-1:0] WRITEDATA = 32'h0;
  logic LINK_UP_STATUS = 1'b0;
  logic NEGOTIATION_TIMEOUT_FLAG = 1'b0;
  logic SEQ_AN_RESTARTED = 1'b0;
  logic [DATA_W-1:0] READDATA;
  logic READVALID, SEQ_RESTART, AN_TIMER_OFF, LF_TIMER_OFF;
  logic FEC_ADVERTISE, FEC_ERR_TO_PCS;
  logic [2:0] SEQ_FORCE_MODE;
  logic [7:0] outs;
  logic [31:0] ctrl_exp = 32'h0;
  logic [2:0] mode_tab [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2};
  int n_fail = 0;
  int comparisons = 0;
  assign outs = {SEQ_RESTART, SEQ_FORCE_MODE, AN_TIMER_OFF, LF_TIMER_OFF,
    FEC_ADVERTISE, FEC_ERR_TO_PCS};
  kr_sequencer_control_regs u_dut (.MCLK(MCLK), .RST(RST),
    .ADDRESS(ADDRESS), .WRITE(WRITE), .READ(READ), .WRITEDATA(WRITEDATA),
    .READDATA(READDATA), .READVALID(READVALID),
    .LINK_UP_STATUS(LINK_UP_STATUS), .NEGOTIATION_TIMEOUT_FLAG(NEGOTIATION_TIMEOUT_FLAG),
    .SEQ_AN_RESTARTED(SEQ_AN_RESTARTED), .SEQ_RESTART(SEQ_RESTART),
    .SEQ_FORCE_MODE(SEQ_FORCE_MODE), .AN_TIMER_OFF(AN_TIMER_OFF),
    .LF_TIMER_OFF(LF_TIMER_OFF), .FEC_ADVERTISE(FEC_ADVERTISE),
    .FEC_ERR_TO_PCS(FEC_ERR_TO_PCS));
  initial begin
    forever #2 MCLK = ~MCLK;
  end
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Only the control word is writable; the restart bit never reads back.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDRESS <= a;
    WRITE <= 1'b1;
    WRITEDATA <= d;
    @(posedge MCLK);
    WRITE <= 1'b0;
    if (a == SEQ_CTRL_ADDR) ctrl_exp = d & 32'h0003_0076;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge MCLK);
    ADDRESS <= a;
    READ <= 1'b1;
    @(posedge MCLK);
    READ <= 1'b0;
    #1;
    chk("READVALID", 32'h1, {31'h0, READVALID});
    chk("READDATA", exp, READDATA);
  endtask
  task automatic end_of_test;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    $display("watchdog expired");
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    #1;
    chk("reset outputs", 32'h0, {24'h0, outs});
    rd(SEQ_CTRL_ADDR, 32'h0);
    rd(SEQ_STAT_ADDR, 32'h0);
    $display("test reset done");
    wr(SEQ_CTRL_ADDR, 32'h0003_0056);
    chk("field outputs", 32'h0f, {24'h0, outs});
    rd(SEQ_CTRL_ADDR, 32'h0003_0056);
    $display("test fields done");
    for (int i = 0; i < 5; i++) begin
      wr(SEQ_CTRL_ADDR, {15'h0, i[0], 9'h0, mode_tab[i], 4'h1});
      chk("SEQ_RESTART", 32'h1, {31'h0, SEQ_RESTART});
      chk("SEQ_FORCE_MODE", {29'h0, mode_tab[i]}, {29'h0, SEQ_FORCE_MODE});
      @(posedge MCLK);
      #1;
      chk("SEQ_RESTART", 32'h0, {31'h0, SEQ_RESTART});
      rd(SEQ_CTRL_ADDR, {15'h0, i[0], 9'h0, mode_tab[i], 4'h0});
    end
    $display("test restart done");
    // Software writes only defined words and changes them by read-modify-write.
    wr(SEQ_CTRL_ADDR, ctrl_exp | 32'h0000_0002);
    chk("AN_TIMER_OFF", 32'h1, {31'h0, AN_TIMER_OFF});
    rd(SEQ_CTRL_ADDR, ctrl_exp);
    rd(8'hc0, UNMAPPED_READ);
    rd(8'h10, UNMAPPED_READ);
    $display("test unmapped done");
    @(posedge MCLK);
    LINK_UP_STATUS <= 1'b1;
    NEGOTIATION_TIMEOUT_FLAG <= 1'b1;
    SEQ_AN_RESTARTED <= 1'b1;
    @(posedge MCLK);
    NEGOTIATION_TIMEOUT_FLAG <= 1'b0;
    SEQ_AN_RESTARTED <= 1'b0;
    rd(SEQ_STAT_ADDR, {14'h0, ctrl_exp[17:16], 16'h3});
    @(posedge MCLK);
    SEQ_AN_RESTARTED <= 1'b1;
    LINK_UP_STATUS <= 1'b0;
    @(posedge MCLK);
    SEQ_AN_RESTARTED <= 1'b0;
    rd(SEQ_STAT_ADDR, {14'h0, ctrl_exp[17:16], 16'h0});
    $display("test status done");
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    #1;
    chk("reset outputs", 32'h0, {24'h0, outs});
    rd(SEQ_CTRL_ADDR, 32'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== src/kr_sequencer_control_regs.sv ====
// Purpose: Control and status words of the backplane link sequencer.
// Assumes: One management port, word addressed, one-cycle read latency.
// Notes: Restart self-clears, so it always reads back as zero.
`timescale 1ns/1ps
`default_nettype none
module kr_sequencer_control_regs
  import seqctl_pkg::*;
#(
  parameter bit FEC_ABILITY_AT_RESET = 1'b0
)(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic WRITE,
  input wire logic READ,
  input wire logic [DATA_W-1:0] WRITEDATA,
  output logic [DATA_W-1:0] READDATA,
  output logic READVALID,
  input wire logic LINK_UP_STATUS,
  input wire logic NEGOTIATION_TIMEOUT_FLAG,
  input wire logic SEQ_AN_RESTARTED,
  output logic SEQ_RESTART,
  output logic [2:0] SEQ_FORCE_MODE,
  output logic AN_TIMER_OFF,
  output logic LF_TIMER_OFF,
  output logic FEC_ADVERTISE,
  output logic FEC_ERR_TO_PCS
);

  typedef struct packed {
    ctrl_fields_t ctrl;
    seq_status_t stat;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;
  logic wr_ctrl;
  logic restart_req;
  logic in_space;

  // Only the two implemented words decode; the rest of the space reads zero.
  assign in_space = (ADDRESS >= KR_SPACE_LO) && (ADDRESS <= KR_SPACE_HI);
  assign wr_ctrl = WRITE && (ADDRESS == SEQ_CTRL_ADDR);
  assign restart_req = wr_ctrl && WRITEDATA[RESTART_BIT];

  always_comb begin
    next_st = st;
    next_st.rvalid = READ;
    next_st.rdata = UNMAPPED_READ;
    if (wr_ctrl) begin
      next_st.ctrl.negotiation_timer_off = WRITEDATA[AN_TMR_OFF_BIT];
      next_st.ctrl.fault_timer_off = WRITEDATA[LF_TMR_OFF_BIT];
      next_st.ctrl.protocol_force_select =
        WRITEDATA[FORCE_MSB:FORCE_LSB];
      next_st.ctrl.fec_capability_advertise = WRITEDATA[FEC_ADV_BIT];
      next_st.ctrl.fec_error_report_enable = WRITEDATA[FEC_ERR_BIT];
    end
    next_st.stat.link_up_status = LINK_UP_STATUS;
    // A new timeout in the restart cycle wins, so no event is lost.
    if (NEGOTIATION_TIMEOUT_FLAG) begin
      next_st.stat.negotiation_timeout_flag = 1'b1;
    end else if (SEQ_AN_RESTARTED) begin
      next_st.stat.negotiation_timeout_flag = 1'b0;
    end
    if (READ && in_space) begin
      if (ADDRESS == SEQ_CTRL_ADDR) begin
        next_st.rdata[AN_TMR_OFF_BIT] = st.ctrl.negotiation_timer_off;
        next_st.rdata[LF_TMR_OFF_BIT] = st.ctrl.fault_timer_off;
        next_st.rdata[FORCE_MSB:FORCE_LSB] = st.ctrl.protocol_force_select;
        next_st.rdata[FEC_ADV_BIT] = st.ctrl.fec_capability_advertise;
        next_st.rdata[FEC_ERR_BIT] = st.ctrl.fec_error_report_enable;
        next_st.rdata[RESTART_BIT] = 1'b0;
      end else if (ADDRESS == SEQ_STAT_ADDR) begin
        next_st.rdata[LINK_UP_BIT] = st.stat.link_up_status;
        next_st.rdata[AN_TIMEOUT_BIT] = st.stat.negotiation_timeout_flag;
        next_st.rdata[FEC_ADV_BIT] = st.ctrl.fec_capability_advertise;
        next_st.rdata[FEC_ERR_BIT] = st.ctrl.fec_error_report_enable;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st <= '0;
      st.ctrl.fec_capability_advertise <= FEC_ABILITY_AT_RESET;
    end else begin
      st <= next_st;
    end
  end

  seq_restart_pulse u_restart (
    .clk(MCLK),
    .rst(RST),
    .restart_req(restart_req),
    .mode_in(WRITEDATA[FORCE_MSB:FORCE_LSB]),
    .restart_pulse(SEQ_RESTART),
    .mode_applied(SEQ_FORCE_MODE)
  );

  assign AN_TIMER_OFF = st.ctrl.negotiation_timer_off;
  assign LF_TIMER_OFF = st.ctrl.fault_timer_off;
  assign FEC_ADVERTISE = st.ctrl.fec_capability_advertise;
  assign FEC_ERR_TO_PCS = st.ctrl.fec_error_report_enable;
  assign READDATA = st.rdata;
  assign READVALID = st.rvalid;

  a_restart_pulse: assert property (@(posedge MCLK) disable iff (RST)
    restart_req |=> SEQ_RESTART ##1 !SEQ_RESTART || $past(restart_req))
    else $error("Restart pulse not one cycle after the write.");
  a_restart_cause: assert property (@(posedge MCLK) disable iff (RST)
    SEQ_RESTART |-> $past(restart_req))
    else $error("Restart issued without a write.");
  a_an_timer: assert property (@(posedge MCLK) disable iff (RST)
    wr_ctrl |=> AN_TIMER_OFF == $past(WRITEDATA[AN_TMR_OFF_BIT]))
    else $error("Negotiation timer gate did not follow the write.");
  a_lf_timer: assert property (@(posedge MCLK) disable iff (RST)
    wr_ctrl |=> LF_TIMER_OFF == $past(WRITEDATA[LF_TMR_OFF_BIT]))
    else $error("Fault timer gate did not follow the write.");
  a_force_apply: assert property (@(posedge MCLK) disable iff (RST)
    restart_req |=> SEQ_FORCE_MODE == st.ctrl.protocol_force_select)
    else $error("Forced protocol not applied with restart.");
  a_fec_err: assert property (@(posedge MCLK) disable iff (RST)
    wr_ctrl |=> FEC_ERR_TO_PCS == $past(WRITEDATA[FEC_ERR_BIT]))
    else $error("FEC error report enable did not follow the write.");
  a_reset_zero: assert property (@(posedge MCLK)
    $past(RST) |-> !AN_TIMER_OFF && !LF_TIMER_OFF && !SEQ_RESTART)
    else $error("Control bits not zero after reset.");
  a_timeout_hold: assert property (@(posedge MCLK) disable iff (RST)
    st.stat.negotiation_timeout_flag && !SEQ_AN_RESTARTED
    |=> st.stat.negotiation_timeout_flag)
    else $error("Timeout flag dropped without a restart.");
  a_restart_rd0: assert property (@(posedge MCLK) disable iff (RST)
    READ && ADDRESS == SEQ_CTRL_ADDR |=> !READDATA[RESTART_BIT])
    else $error("Restart bit read back as one.");
  a_link_ready: assert property (@(posedge MCLK) disable iff (RST)
    READ && ADDRESS == SEQ_STAT_ADDR
    |=> READDATA[LINK_UP_BIT] == $past(st.stat.link_up_status))
    else $error("Link ready read back wrong.");

endmodule
`default_nettype wire

// ==== src/seq_restart_pulse.sv ====
// Purpose: Turns a restart write into one-cycle pulse and latches the mode.
// Assumes: Write strobe is synchronous to MCLK.
// Notes: The force mode seen by the sequencer changes only here.
`timescale 1ns/1ps
`default_nettype none
module seq_restart_pulse
  import seqctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic restart_req,
  input wire logic [2:0] mode_in,
  output logic restart_pulse,
  output logic [2:0] mode_applied
);

  typedef struct packed {
    logic pulse;
    logic [2:0] mode;
  } rp_state_t;

  rp_state_t st;
  rp_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.pulse = restart_req;
    if (restart_req) begin
      next_st.mode = mode_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign restart_pulse = st.pulse;
  assign mode_applied = st.mode;

  a_mode_holds: assert property (@(posedge clk) disable iff (rst)
    !restart_req |=> mode_applied == $past(mode_applied))
    else $error("Applied force mode changed without a restart.");

endmodule
`default_nettype wire

// ==== src/seqctl_pkg.sv ====
// Purpose: Shared constants and carriers for the link sequencer control bank.
// Assumes: One word-addressed management space with 32-bit data.
// Notes: Offsets are word addresses.
package seqctl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] SEQ_CTRL_ADDR = 8'hb0;
  localparam logic [ADDR_W-1:0] SEQ_STAT_ADDR = 8'hb1;
  localparam logic [ADDR_W-1:0] KR_SPACE_LO = 8'hb0;
  localparam logic [ADDR_W-1:0] KR_SPACE_HI = 8'hff;

  localparam int RESTART_BIT = 0;
  localparam int AN_TMR_OFF_BIT = 1;
  localparam int LF_TMR_OFF_BIT = 2;
  localparam int FORCE_LSB = 4;
  localparam int FORCE_MSB = 6;
  localparam int FEC_ADV_BIT = 16;
  localparam int FEC_ERR_BIT = 17;

  localparam int LINK_UP_BIT = 0;
  localparam int AN_TIMEOUT_BIT = 1;

  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [2:0] {
    FORCE_NONE = 3'h0,
    FORCE_GIGE = 3'h1,
    FORCE_10GR = 3'h4,
    FORCE_10GKR = 3'h5
  } force_mode_t;

  typedef struct packed {
    logic negotiation_timer_off;
    logic fault_timer_off;
    logic [2:0] protocol_force_select;
    logic fec_capability_advertise;
    logic fec_error_report_enable;
  } ctrl_fields_t;

  typedef struct packed {
    logic link_up_status;
    logic negotiation_timeout_flag;
  } seq_status_t;

endpackage
